/* File: sim/sbgsr_pulse_src.sv */
// Pulse train source on the far side of the gear input.
// Assumes start is held during reset with a count of zero.
`timescale 1ns/1ps
module sbgsr_pulse_src (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] count,
  output logic pulse,
  output logic busy
);
  logic [7:0] left_q;
  logic [2:0] ph_q;
  // Eight-cycle period keeps each level well past the input synchroniser
  always_ff @(posedge clk)
  begin
    if (start)
    begin
      left_q <= count;
      ph_q <= 3'h0;
    end
    else if (left_q != 8'h00)
    begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7)
        left_q <= left_q - 8'h01;
    end
  end
  // Line is pulled low when idle
  assign busy = left_q != 8'h00;
  assign pulse = busy && !ph_q[2];
endmodule // sbgsr_pulse_src

/* File: sim/sbgsr_tb.sv */
// Self-checking bench of the servo brake, gear and encoder block.
// Assumes a 125 MHz clock and a 20-cycle update tick.
`timescale 1ns/1ps
module servo_brake_gear_speed_reach_tb_top;
  import sbgsr_pkg::*;
  logic clk = 1'b0;
  logic rst_b, psel, penable, pwrite, estop, fault, exal, encerr;
  logic pready, pslverr, rerr, brake, poscmd, encp, encf, reached;
  logic p_in, p_start, p_busy;
  logic [7:0] p_cnt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic signed [15:0] speed, acmd;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_pos = 0;
  int n_enc = 0;
  sbgsr_top #(.UPD_CYCLES(20)) sbgsr_top_i (
    .CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EMERGENCY_STOP_IN(estop),
    .PULSE_IN(p_in), .FAULT_IN(fault), .EXCLUDED_ALARM_IN(exal),
    .ENCODER_ERR_IN(encerr), .MOTOR_SPEED(speed),
    .SPEED_CMD_ANALOG(acmd), .BRAKE_RELEASE_OUT(brake),
    .POS_CMD_PULSE(poscmd), .ENC_OUT_PULSE(encp),
    .ENCODER_OUTPUT_FAULT(encf), .SPEED_REACHED_OUT(reached));
  sbgsr_pulse_src sbgsr_pulse_src_i (.clk(clk), .start(p_start),
    .count(p_cnt), .pulse(p_in), .busy(p_busy));
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (poscmd === 1'b1)
      n_pos <= n_pos + 1;
    if (encp === 1'b1)
      n_enc <= n_enc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_for(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wait_low(output int n);
    n = 0;
    while (brake === 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic pulses(input int exp);
    int base;
    base = n_pos;
    p_cnt <= 8'h08;
    p_start <= 1'b1;
    wait_for(1);
    p_start <= 1'b0;
    wait_for(1);
    while (p_busy === 1'b1)
      @(posedge clk);
    wait_for(8);
    check(32'(n_pos - base), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, A_NUM1, 32'h0);
    check(rdat, 32'h80);
    apb(1'b0, A_DEN, 32'h0);
    check(rdat, 32'ha);
    apb(1'b0, A_PPR, 32'h0);
    check(rdat, 32'h9c4);
    apb(1'b0, A_RANGE, 32'h0);
    check(rdat, 32'ha);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(rerr), 32'h1);
  endtask
  task automatic t_gear();
    apb(1'b1, A_NUM1, 32'h5);
    check(32'(rerr), 32'h1);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_NUM1, 32'h5);
    check(32'(rerr), 32'h0);
    apb(1'b1, A_DEN, 32'h7);
    check(32'(rerr), 32'h1);
    apb(1'b1, A_CTRL, 32'h3);
    apb(1'b1, A_NUMX, 32'h6);
    check(32'(rerr), 32'h1);
    apb(1'b1, A_CTRL, 32'h2);
    apb(1'b1, A_NUMX, 32'h6);
    check(32'(rerr), 32'h0);
    apb(1'b1, A_NUM1, 32'h3);
    apb(1'b1, A_DEN, 32'h2);
    apb(1'b0, A_DEN, 32'h0);
    check(rdat, 32'h2);
    pulses(12);
    apb(1'b1, A_CTRL, 32'h6);
    pulses(24);
  endtask
  task automatic t_brake();
    int n;
    speed <= 16'sd500;
    apb(1'b1, A_OFF_DLY, 32'h2);
    apb(1'b1, A_CTRL, 32'h1);
    wait_for(1);
    check(32'(brake), 32'h1);
    apb(1'b1, A_CTRL, 32'h0);
    wait_low(n);
    check(32'(n >= 18 && n <= 42), 32'h1);
    apb(1'b1, A_OFF_DLY, 32'ha);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_CTRL, 32'h0);
    wait_for(5);
    check(32'(brake), 32'h1);
    speed <= 16'sd0;
    wait_low(n);
    check(32'(n <= 3), 32'h1);
    speed <= 16'sd500;
    apb(1'b1, A_OFF_DLY, 32'hfffb);
    apb(1'b1, A_CTRL, 32'h1);
    wait_for(1);
    fault <= 1'b1;
    wait_low(n);
    check(32'(n >= 1 && n <= 3), 32'h1);
    speed <= 16'sd0;
    estop <= 1'b1;
    wait_for(8);
    fault <= 1'b0;
    estop <= 1'b0;
    // Excluded alarm keeps the five tick delay; a stop forces it to zero
    speed <= 16'sd500;
    wait_for(4);
    exal <= 1'b1;
    fault <= 1'b1;
    wait_for(40);
    check(32'(brake), 32'h1);
    wait_low(n);
    check(32'(n >= 30 && n <= 80), 32'h1);
    fault <= 1'b0;
    exal <= 1'b0;
    wait_for(4);
    estop <= 1'b1;
    wait_low(n);
    check(32'(n >= 2 && n <= 5), 32'h1);
    estop <= 1'b0;
    speed <= 16'sd0;
    apb(1'b1, A_CTRL, 32'h0);
  endtask
  task automatic t_enc();
    int base;
    apb(1'b1, A_PPR, 32'd320000);
    speed <= 16'sd928;
    wait_for(3);
    check(32'(encf), 32'h0);
    speed <= 16'sd929;
    wait_for(3);
    check(32'(encf), 32'h1);
    apb(1'b1, A_ELIM, 32'd900);
    speed <= 16'sd901;
    wait_for(3);
    check(32'(encf), 32'h1);
    speed <= 16'sd900;
    wait_for(3);
    check(32'(encf), 32'h0);
    base = n_enc;
    wait_for(2604);
    check(32'(n_enc - base >= 98 && n_enc - base <= 101), 32'h1);
    encerr <= 1'b1;
    wait_for(4);
    check(32'(encf), 32'h1);
    encerr <= 1'b0;
  endtask
  task automatic t_reach();
    speed <= 16'sd100;
    acmd <= 16'sd100;
    apb(1'b1, A_SCMD, 32'd100);
    apb(1'b1, A_CTRL, 32'h8);
    wait_for(600);
    check(32'(reached), 32'h1);
    apb(1'b1, A_SCMD, 32'd120);
    wait_for(3);
    check(32'(reached), 32'h0);
    apb(1'b1, A_CTRL, 32'h0);
    wait_for(3);
    check(32'(reached), 32'h1);
    apb(1'b1, A_RANGE, 32'h0);
    wait_for(3);
    check(32'(reached), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_b, psel, penable, pwrite, estop, fault, exal, encerr} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    speed = 16'sd0;
    acmd = 16'sd0;
    p_start = 1'b1;
    p_cnt = 8'h00;
    wait_for(12);
    rst_b <= 1'b1;
    p_start <= 1'b0;
    wait_for(1);
    t_regs();
    t_gear();
    t_brake();
    t_enc();
    t_reach();
    results();
  end
endmodule // servo_brake_gear_speed_reach_tb_top

/* File: sim/sbgsr_top_sva.sv */
// Port checker of the servo brake, gear and encoder block.
// Sees only sbgsr_top ports; the bind follows the module.
`timescale 1ns/1ps
module sbgsr_top_sva (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PSLVERR,
  input wire logic EMERGENCY_STOP_IN,
  input wire logic FAULT_IN,
  input wire logic ENCODER_ERR_IN,
  input wire logic signed [15:0] MOTOR_SPEED,
  input wire logic BRAKE_RELEASE_OUT,
  input wire logic ENC_OUT_PULSE,
  input wire logic ENCODER_OUTPUT_FAULT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////
  // Zero speed sits under any nonzero threshold, so no register is needed
  sequence fault_at_rest;
    (FAULT_IN && MOTOR_SPEED == 16'sh0000) [*4];
  endsequence
  sequence estop_at_rest;
    (EMERGENCY_STOP_IN && MOTOR_SPEED == 16'sh0000) [*6];
  endsequence
  chk_fault_brake:
  assert property (fault_at_rest |-> !BRAKE_RELEASE_OUT)
    else $error("brake released in fault at rest");
  chk_estop_brake:
  assert property (estop_at_rest |-> !BRAKE_RELEASE_OUT)
    else $error("brake released in stop at rest");
  chk_err_fault:
  assert property (ENCODER_ERR_IN |=> ENCODER_OUTPUT_FAULT)
    else $error("encoder error without fault");
  chk_rest_nofault:
  assert property (!ENCODER_ERR_IN && MOTOR_SPEED == 16'sh0000
    |=> !ENCODER_OUTPUT_FAULT)
    else $error("fault with motor at rest");
  chk_err_nopulse:
  assert property (ENCODER_ERR_IN [*3] |=> !ENC_OUT_PULSE)
    else $error("encoder pulse during fault");
  chk_rest_nopulse:
  assert property (MOTOR_SPEED == 16'sh0000 [*3] |=> !ENC_OUT_PULSE)
    else $error("encoder pulse at rest");
  chk_release_cause:
  assert property ($rose(BRAKE_RELEASE_OUT) |->
    !$past(FAULT_IN) && !$past(ENCODER_OUTPUT_FAULT))
    else $error("brake released while faulted");
  chk_err_access:
  assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("slave error outside access");
endmodule // sbgsr_top_sva
bind sbgsr_top sbgsr_top_sva sbgsr_top_sva_i (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PSLVERR(PSLVERR), .EMERGENCY_STOP_IN(EMERGENCY_STOP_IN),
  .FAULT_IN(FAULT_IN), .ENCODER_ERR_IN(ENCODER_ERR_IN),
  .MOTOR_SPEED(MOTOR_SPEED), .BRAKE_RELEASE_OUT(BRAKE_RELEASE_OUT),
  .ENC_OUT_PULSE(ENC_OUT_PULSE),
  .ENCODER_OUTPUT_FAULT(ENCODER_OUTPUT_FAULT)
);

/* File: src/sbgsr_pkg.sv */
// Constants, register map and carrier types of the servo brake/gear block.
// Assumes one 125 MHz system clock and an APB master with 32-bit data.
package sbgsr_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint CLK_HZ = 125000000;
  localparam int UPD_PERIOD_US = 1000;
  localparam int UPD_CYC = int'(CLK_HZ / 1000000) * UPD_PERIOD_US;
  localparam logic [39:0] ENC_DIV = 40'(60 * CLK_HZ);
  localparam logic [35:0] ENC_RATE_MAX = 36'd297000000;
  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_OFF_DLY = 12'h156;
  localparam logic [11:0] IDX_NUM1 = 12'h158;
  localparam logic [11:0] IDX_DEN = 12'h15a;
  localparam logic [11:0] IDX_PPR = 12'h15c;
  localparam logic [11:0] IDX_RANGE = 12'h15e;
  localparam logic [11:0] IDX_PDONE = 12'h160;
  localparam logic [11:0] IDX_CTRL = 12'h180;
  localparam logic [11:0] IDX_STAT = 12'h182;
  localparam logic [11:0] IDX_SCMD = 12'h184;
  localparam logic [11:0] IDX_BTHR = 12'h186;
  localparam logic [11:0] IDX_ELIM = 12'h188;
  localparam logic [11:0] IDX_NUMX = 12'h18a;
  localparam logic [11:0] A_OFF_DLY = {IDX_OFF_DLY[9:0], 2'b00};
  localparam logic [11:0] A_NUM1 = {IDX_NUM1[9:0], 2'b00};
  localparam logic [11:0] A_DEN = {IDX_DEN[9:0], 2'b00};
  localparam logic [11:0] A_PPR = {IDX_PPR[9:0], 2'b00};
  localparam logic [11:0] A_RANGE = {IDX_RANGE[9:0], 2'b00};
  localparam logic [11:0] A_PDONE = {IDX_PDONE[9:0], 2'b00};
  localparam logic [11:0] A_CTRL = {IDX_CTRL[9:0], 2'b00};
  localparam logic [11:0] A_STAT = {IDX_STAT[9:0], 2'b00};
  localparam logic [11:0] A_SCMD = {IDX_SCMD[9:0], 2'b00};
  localparam logic [11:0] A_BTHR = {IDX_BTHR[9:0], 2'b00};
  localparam logic [11:0] A_ELIM = {IDX_ELIM[9:0], 2'b00};
  localparam logic [11:0] A_NUMX = {IDX_NUMX[9:0], 2'b00};
  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] RST_OFF_DLY = 16'h0000;
  localparam logic [31:0] RST_NUM1 = 32'h00000080;
  localparam logic [31:0] RST_DEN = 32'h0000000a;
  localparam logic [31:0] RST_PPR = 32'h000009c4;
  localparam logic [31:0] RST_RANGE = 32'h0000000a;
  localparam logic [15:0] RST_PDONE = 16'h0000;
  localparam logic [15:0] RST_SCMD = 16'h0000;
  localparam logic [15:0] RST_BTHR = 16'h000a;
  localparam logic [15:0] RST_ELIM = 16'h1388;
  localparam logic [31:0] RST_NUMX = 32'h00000080;
  ////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic cmd_from_reg;
    logic num_sel_extra;
    logic mode_pr;
    logic servo_on;
  } sbgsr_ctrl_t;
  localparam sbgsr_ctrl_t RST_CTRL = 4'h0;
  typedef struct packed {
    logic servo_en;
    logic reached;
    logic enc_fault;
    logic brake_release;
  } sbgsr_stat_t;
  typedef enum logic [1:0] {
    BRK_RUN = 2'b00,
    BRK_DELAY = 2'b01,
    BRK_HOLD = 2'b11
  } sbgsr_brk_t;
endpackage

/* File: src/sbgsr_top.sv */
// Brake release delay, electronic gear, encoder pulse output with its
// overspeed fault, and speed-reached comparator, with an APB register file.
// Assumes speeds come from logic on CLK_SYS and the two pins are asynchronous.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module sbgsr_top #(
  parameter int UPD_CYCLES = sbgsr_pkg::UPD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EMERGENCY_STOP_IN,
  input wire logic PULSE_IN,
  input wire logic FAULT_IN,
  input wire logic EXCLUDED_ALARM_IN,
  input wire logic ENCODER_ERR_IN,
  input wire logic signed [15:0] MOTOR_SPEED,
  input wire logic signed [15:0] SPEED_CMD_ANALOG,
  output logic BRAKE_RELEASE_OUT,
  output logic POS_CMD_PULSE,
  output logic ENC_OUT_PULSE,
  output logic ENCODER_OUTPUT_FAULT,
  output logic SPEED_REACHED_OUT
);
  import sbgsr_pkg::*;

  function automatic logic [16:0] sbgsr_abs(input logic signed [16:0] v);
    sbgsr_abs = v[16] ? 17'(-v) : 17'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [15:0] off_dly_q;
  logic [31:0] num1_q;
  logic [31:0] den_q;
  logic [31:0] ppr_q;
  logic [31:0] range_q;
  logic [15:0] pdone_q;
  logic [15:0] scmd_q;
  logic [15:0] bthr_q;
  logic [15:0] elim_q;
  logic [31:0] numx_q;
  sbgsr_ctrl_t ctrl_q;
  sbgsr_stat_t stat;
  sbgsr_brk_t brk_q;
  logic [10:0] dly_cnt_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic estop_s1_q;
  logic estop_s2_q;
  logic pulse_s1_q;
  logic pulse_s2_q;
  logic pulse_s3_q;
  logic [41:0] gear_acc_q;
  logic [40:0] enc_acc_q;
  logic signed [15:0] spd_f_q;
  logic enc_fault_q;
  logic reached_q;
  logic pos_pulse_q;
  logic enc_pulse_q;
  logic [31:0] prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and control update tick
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      estop_s1_q <= 1'b0;
      estop_s2_q <= 1'b0;
      pulse_s1_q <= 1'b0;
      pulse_s2_q <= 1'b0;
      pulse_s3_q <= 1'b0;
    end
    else
    begin
      estop_s1_q <= EMERGENCY_STOP_IN;
      estop_s2_q <= estop_s1_q;
      pulse_s1_q <= PULSE_IN;
      pulse_s2_q <= pulse_s1_q;
      pulse_s3_q <= pulse_s2_q;
    end
  end

  assign tick = (tick_cnt_q == 32'(UPD_CYCLES - 1));

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      tick_cnt_q <= 32'h0;
    else if (tick)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Servo state and speed terms
  logic servo_en;
  logic fault_cause;
  logic [16:0] spd_abs;
  logic [10:0] dly_ms;
  logic signed [15:0] cmd;
  logic [16:0] spd_err;
  logic [35:0] enc_rate;

  assign servo_en = ctrl_q.servo_on & ~FAULT_IN & ~estop_s2_q & ~enc_fault_q;
  // Excluded alarm does not count as a fault cause for the delay
  assign fault_cause = (FAULT_IN & ~EXCLUDED_ALARM_IN) | estop_s2_q
                       | enc_fault_q;
  assign spd_abs = sbgsr_abs(17'(MOTOR_SPEED));

  always_comb
  begin
    dly_ms = off_dly_q[10:0];
    if (off_dly_q[15])
      dly_ms = fault_cause ? 11'h0 : 11'(-off_dly_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // Brake release sequence
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      brk_q <= BRK_HOLD;
      dly_cnt_q <= 11'h0;
    end
    else
    begin
      unique case (brk_q)
        BRK_RUN:
        begin
          if (!servo_en)
          begin
            dly_cnt_q <= dly_ms;
            brk_q <= (dly_ms == 11'h0) ? BRK_HOLD : BRK_DELAY;
          end
        end
        BRK_DELAY:
        begin
          if (servo_en)
            brk_q <= BRK_RUN;
          else if (spd_abs < {1'b0, bthr_q})
            brk_q <= BRK_HOLD;
          else if (tick)
          begin
            dly_cnt_q <= dly_cnt_q - 11'h1;
            if (dly_cnt_q == 11'h1)
              brk_q <= BRK_HOLD;
          end
        end
        BRK_HOLD:
        begin
          if (servo_en)
            brk_q <= BRK_RUN;
        end
      endcase
    end
  end

  assign BRAKE_RELEASE_OUT = (brk_q != BRK_HOLD);

  ////////////////////////////////////////////////////////////////////////
  // Electronic gear: one command pulse per M accumulated units
  logic [41:0] gear_sum;
  logic [31:0] num_act;

  assign num_act = ctrl_q.num_sel_extra ? numx_q : num1_q;
  assign gear_sum = gear_acc_q
                    + ((pulse_s2_q & ~pulse_s3_q) ? {10'h0, num_act} : 42'h0);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      gear_acc_q <= 42'h0;
      pos_pulse_q <= 1'b0;
    end
    else if (gear_sum >= {10'h0, den_q})
    begin
      gear_acc_q <= gear_sum - {10'h0, den_q};
      pos_pulse_q <= 1'b1;
    end
    else
    begin
      gear_acc_q <= gear_sum;
      pos_pulse_q <= 1'b0;
    end
  end

  assign POS_CMD_PULSE = pos_pulse_q;

  ////////////////////////////////////////////////////////////////////////
  // Encoder output pulses and their fault
  // Rate in r/min times pulses per turn; one pulse per 60 s of clocks
  assign enc_rate = 36'(spd_abs) * 36'(ppr_q[18:0]);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B || enc_fault_q)
    begin
      enc_acc_q <= 41'h0;
      enc_pulse_q <= 1'b0;
    end
    else if (enc_acc_q >= {1'b0, ENC_DIV})
    begin
      enc_acc_q <= enc_acc_q - {1'b0, ENC_DIV} + {5'h0, enc_rate};
      enc_pulse_q <= 1'b1;
    end
    else
    begin
      enc_acc_q <= enc_acc_q + {5'h0, enc_rate};
      enc_pulse_q <= 1'b0;
    end
  end

  // Level fault: clears as soon as every cause has gone
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      enc_fault_q <= 1'b0;
    else
      enc_fault_q <= ENCODER_ERR_IN | (spd_abs > {1'b0, elim_q})
                     | (enc_rate > ENC_RATE_MAX);
  end

  assign ENC_OUT_PULSE = enc_pulse_q;
  assign ENCODER_OUTPUT_FAULT = enc_fault_q;

  ////////////////////////////////////////////////////////////////////////
  // Speed reached comparator
  logic signed [16:0] f_diff;

  assign f_diff = 17'(MOTOR_SPEED) - 17'(spd_f_q);

  // Quarter-step low-pass on the update tick; trades lag for quiet output
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      spd_f_q <= 16'sh0;
    else if (tick)
      spd_f_q <= 16'(spd_f_q + 16'(f_diff >>> 2));
  end

  assign cmd = ctrl_q.cmd_from_reg ? scmd_q : SPEED_CMD_ANALOG;
  assign spd_err = sbgsr_abs(17'(cmd) - 17'(spd_f_q));

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      reached_q <= 1'b0;
    else
      reached_q <= (range_q != 32'h0)
                   && ({15'h0, spd_err} <= range_q);
  end

  assign SPEED_REACHED_OUT = reached_q;

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  logic acc;
  logic wr;
  logic hit;
  logic num_ok;
  logic den_ok;
  logic rej;
  logic [31:0] rdata;

  assign acc = PSEL & PENABLE;
  assign wr = acc & PWRITE;
  assign num_ok = ctrl_q.mode_pr ? ~servo_en : servo_en;
  assign den_ok = ~servo_en;
  assign stat = '{servo_en: servo_en, reached: reached_q,
                  enc_fault: enc_fault_q, brake_release: BRAKE_RELEASE_OUT};

  always_comb
  begin
    hit = 1'b1;
    rdata = 32'h0;
    unique case (PADDR)
      A_OFF_DLY: rdata = {16'h0, off_dly_q};
      A_NUM1: rdata = num1_q;
      A_DEN: rdata = den_q;
      A_PPR: rdata = ppr_q;
      A_RANGE: rdata = range_q;
      A_PDONE: rdata = {16'h0, pdone_q};
      A_CTRL: rdata = {28'h0, ctrl_q};
      A_STAT: rdata = {28'h0, stat};
      A_SCMD: rdata = {16'h0, scmd_q};
      A_BTHR: rdata = {16'h0, bthr_q};
      A_ELIM: rdata = {16'h0, elim_q};
      A_NUMX: rdata = numx_q;
      default: hit = 1'b0;
    endcase
  end

  assign rej = PWRITE & ((((PADDR == A_NUM1) | (PADDR == A_NUMX)) & ~num_ok)
               | ((PADDR == A_DEN) & ~den_ok));
  assign PREADY = 1'b1;
  assign PSLVERR = acc & (~hit | rej);
  assign PRDATA = prdata_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      prdata_q <= 32'h0;
    else if (PSEL & ~PENABLE & ~PWRITE)
      prdata_q <= rdata;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      off_dly_q <= RST_OFF_DLY;
      num1_q <= RST_NUM1;
      den_q <= RST_DEN;
      ppr_q <= RST_PPR;
      range_q <= RST_RANGE;
      pdone_q <= RST_PDONE;
      ctrl_q <= RST_CTRL;
      scmd_q <= RST_SCMD;
      bthr_q <= RST_BTHR;
      elim_q <= RST_ELIM;
      numx_q <= RST_NUMX;
    end
    else if (wr && hit && !rej)
    begin
      unique case (PADDR)
        A_OFF_DLY: off_dly_q <= PWDATA[15:0];
        A_NUM1: num1_q <= PWDATA;
        A_DEN: den_q <= PWDATA;
        A_PPR: ppr_q <= PWDATA;
        A_RANGE: range_q <= PWDATA;
        A_PDONE: pdone_q <= PWDATA[15:0];
        A_CTRL: ctrl_q <= PWDATA[3:0];
        A_SCMD: scmd_q <= PWDATA[15:0];
        A_BTHR: bthr_q <= PWDATA[15:0];
        A_ELIM: elim_q <= PWDATA[15:0];
        A_NUMX: numx_q <= PWDATA;
        default: ;
      endcase
    end
  end
endmodule // sbgsr_top
